//--- common/kil_pkg.sv
// package of constants and types for the keypad interrupt latch
package kil_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] KIL_OFF_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] KIL_OFF_ENABLE = 12'h004;
  localparam logic [11:0] KIL_OFF_PORT_DIR = 12'h008;
  localparam logic [11:0] KIL_OFF_PORT_DATA = 12'h00C;
  localparam logic [11:0] KIL_OFF_PIN_LEVEL = 12'h010;

  // ****************************************************************
  // status/control field positions
  // ****************************************************************
  localparam int KIL_BIT_SENSE = 0;
  localparam int KIL_BIT_MASK = 1;
  localparam int KIL_BIT_ACK = 2;
  localparam int KIL_BIT_PENDING = 3;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int KIL_NPINS = 5;
  localparam logic [4:0] KIL_PINS_RESET = 5'h00;
  localparam logic [31:0] KIL_DATA_ZERO = 32'h0000_0000;
  localparam logic [15:0] KIL_VECTOR_HI = 16'hFFE0;
  localparam logic [15:0] KIL_VECTOR_LO = 16'hFFE1;

  typedef enum logic {KIL_MODE_EDGE, KIL_MODE_EDGE_LEVEL} kil_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } kil_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } kil_apb_rsp_t;

  typedef struct packed {
    logic sense_sel;
    logic irq_mask;
    logic ack;
    logic [4:0] pin_enable;
  } kil_ctrl_t;

endpackage : kil_pkg

//--- hw/kil_pin_sync.sv
// two-stage synchroniser for the keypad pins
`timescale 1ns/1ps
module kil_pin_sync
  import kil_pkg::*;
#(
  parameter int WIDTH = KIL_NPINS
)(
  input wire logic mclk, // bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] pin_raw, // raw pin levels
  output logic [WIDTH-1:0] pin_sync // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = pin_raw;
    sync_d = meta_q;
  end

  // idle pins read high, as pulled up
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_sync = sync_q;

endmodule : kil_pin_sync

//--- hw/kil_apb_slave.sv
// apb slave front end: decodes one-cycle read and write strobes
`timescale 1ns/1ps
module kil_apb_slave
  import kil_pkg::*;
(
  input wire kil_apb_req_t apb_req, // apb request from master
  input wire logic [31:0] rd_data, // read value for current address
  input wire logic addr_hit, // address is mapped
  output kil_apb_rsp_t apb_rsp, // apb answer
  output logic wr_stb, // write strobe, one cycle
  output logic rd_stb // read strobe, one cycle
);

  logic access;

  // zero wait states: answer in the access phase
  always_comb
  begin
    access = apb_req.psel && apb_req.penable;
    wr_stb = access && apb_req.pwrite && addr_hit;
    rd_stb = access && !apb_req.pwrite;
    apb_rsp.pready = access;
    apb_rsp.pslverr = access && !addr_hit;
    apb_rsp.prdata = (access && !apb_req.pwrite && addr_hit) ? rd_data
                                                             : KIL_DATA_ZERO;
  end

endmodule : kil_apb_slave

//--- hw/kil_keypad_latch.sv
// keypad interrupt latch with apb registers and port pin control
`timescale 1ns/1ps
// Summary of operation
// - five pins, own enables, one shared mask
// - enabled pin switches on its pullup
// - latch when enabled pin falls, all high
// - sense bit: edge only or edge-level
// - edge mode: no latch if another low
// - edge-level: request held while any low
// - edge-level: clear needs ack and all high
// - vector fetch acknowledges the request
// - writing ack bit acknowledges like fetch
// - edge after ack latches new request
// - unmasked request goes to processor vector
// - edge mode: acknowledge clears at once
// - reset clears request and sense bit
// - pending flag ignores the mask
// - enable forces pin input over direction
// - sense one: edges and levels; zero: edges
// - ack bit write-only, reads zero
// - mask bit blocks processor interrupt
// - pending flag read-only, reset clears
module kil_keypad_latch
  import kil_pkg::*;
#(
  parameter int NPINS = KIL_NPINS
)(
  input wire logic mclk, // bus clock, 250 MHz
  input wire logic rst_n, // async reset, active low
  input wire kil_apb_req_t apb_req, // apb request
  output kil_apb_rsp_t apb_rsp, // apb answer
  input wire logic vector_fetch, // cpu fetches keypad vector, pulse
  output logic kbd_irq, // interrupt request to cpu, level
  output logic [15:0] kbd_vector_addr, // vector address for cpu
  input wire logic [NPINS-1:0] pin_in, // port pin levels
  output logic [NPINS-1:0] pin_out, // port pin drive value
  output logic [NPINS-1:0] pin_oe, // port pin drive enable
  output logic [NPINS-1:0] pin_pullup // port pin pullup enable
);

  // ****************************************************************
  // state
  // ****************************************************************
  kil_mode_t sense_q;
  kil_mode_t sense_d;
  logic mask_q;
  logic mask_d;
  logic [NPINS-1:0] enable_q;
  logic [NPINS-1:0] enable_d;
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] dir_d;
  logic [NPINS-1:0] data_q;
  logic [NPINS-1:0] data_d;
  logic request_q;
  logic request_d;
  logic acked_q;
  logic acked_d;
  logic all_high_q;
  logic all_high_d;

  logic [NPINS-1:0] pin_sync;
  logic wr_stb;
  logic addr_hit;
  logic wr_sc;
  logic wr_enable;
  logic wr_dir;
  logic wr_data;
  logic [31:0] rd_data;
  logic ack_pulse;
  logic all_high;
  logic fall_event;
  logic any_low;
  kil_ctrl_t ctrl;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic [31:0] kil_pad(input logic [NPINS-1:0] v);
    logic [31:0] r;
    r = KIL_DATA_ZERO;
    r[NPINS-1:0] = v;
    return r;
  endfunction : kil_pad

  function automatic logic kil_is_write(input logic [11:0] off,
                                        input logic [11:0] addr,
                                        input logic stb);
    return stb && (addr == off);
  endfunction : kil_is_write

  // pins set as outputs read back as zero
  function automatic logic [NPINS-1:0] kil_level_view(
    input logic [NPINS-1:0] lvl,
    input logic [NPINS-1:0] dir);
    return lvl & ~dir;
  endfunction : kil_level_view

  // ****************************************************************
  // submodules
  // ****************************************************************
  kil_pin_sync #(
    .WIDTH(NPINS)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_raw(pin_in),
    .pin_sync(pin_sync)
  );

  kil_apb_slave u_apb (
    .apb_req(apb_req),
    .rd_data(rd_data),
    .addr_hit(addr_hit),
    .apb_rsp(apb_rsp),
    .wr_stb(wr_stb),
    .rd_stb()
  );

  // ****************************************************************
  // register decode and read mux
  // ****************************************************************
  always_comb
  begin
    addr_hit = 1'b1;
    rd_data = KIL_DATA_ZERO;
    case (apb_req.paddr)
      KIL_OFF_STATUS_CONTROL:
      begin
        rd_data[KIL_BIT_SENSE] = (sense_q == KIL_MODE_EDGE_LEVEL);
        rd_data[KIL_BIT_MASK] = mask_q;
        rd_data[KIL_BIT_ACK] = 1'b0;
        rd_data[KIL_BIT_PENDING] = request_q;
      end
      KIL_OFF_ENABLE: rd_data = kil_pad(enable_q);
      KIL_OFF_PORT_DIR: rd_data = kil_pad(dir_q);
      KIL_OFF_PORT_DATA: rd_data = kil_pad(data_q);
      // level readable only while direction bit is 0
      KIL_OFF_PIN_LEVEL:
        rd_data = kil_pad(kil_level_view(pin_sync, dir_q));
      default: addr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // write strobes
  // ****************************************************************
  // one strobe per writable register, none for pin level
  always_comb
  begin
    wr_sc = kil_is_write(KIL_OFF_STATUS_CONTROL, apb_req.paddr, wr_stb);
    wr_enable = kil_is_write(KIL_OFF_ENABLE, apb_req.paddr, wr_stb);
    wr_dir = kil_is_write(KIL_OFF_PORT_DIR, apb_req.paddr, wr_stb);
    wr_data = kil_is_write(KIL_OFF_PORT_DATA, apb_req.paddr, wr_stb);
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_comb
  begin
    ctrl.sense_sel = apb_req.pwdata[KIL_BIT_SENSE];
    ctrl.irq_mask = apb_req.pwdata[KIL_BIT_MASK];
    ctrl.ack = apb_req.pwdata[KIL_BIT_ACK];
    ctrl.pin_enable = apb_req.pwdata[NPINS-1:0];
    sense_d = sense_q;
    mask_d = mask_q;
    enable_d = enable_q;
    dir_d = dir_q;
    data_d = data_q;
    ack_pulse = vector_fetch;
    if (wr_sc)
    begin
      sense_d = ctrl.sense_sel ? KIL_MODE_EDGE_LEVEL : KIL_MODE_EDGE;
      mask_d = ctrl.irq_mask;
      ack_pulse = vector_fetch || ctrl.ack;
    end
    if (wr_enable)
      enable_d = ctrl.pin_enable;
    if (wr_dir)
      dir_d = apb_req.pwdata[NPINS-1:0];
    if (wr_data)
      data_d = apb_req.pwdata[NPINS-1:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_q <= KIL_MODE_EDGE;
      mask_q <= 1'b0;
      enable_q <= KIL_PINS_RESET;
      dir_q <= KIL_PINS_RESET;
      data_q <= KIL_PINS_RESET;
    end
    else
    begin
      sense_q <= sense_d;
      mask_q <= mask_d;
      enable_q <= enable_d;
      dir_q <= dir_d;
      data_q <= data_d;
    end
  end

  // ****************************************************************
  // pin level detection
  // ****************************************************************
  always_comb
  begin
    // disabled pins count as high
    all_high = &(pin_sync | ~enable_q);
    any_low = !all_high;
    all_high_d = all_high;
    // falling edge only when all were high last cycle
    fall_event = all_high_q && any_low;
  end

  // pins reset high, no false edge after reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      all_high_q <= 1'b1;
    else
      all_high_q <= all_high_d;
  end

  // ****************************************************************
  // request latch and acknowledge
  // ****************************************************************
  always_comb
  begin
    request_d = request_q;
    acked_d = acked_q;
    case (sense_q)
      KIL_MODE_EDGE:
      begin
        acked_d = 1'b0;
        // acknowledge clears at once, pins ignored
        if (ack_pulse)
          request_d = 1'b0;
        if (fall_event)
          request_d = 1'b1; // set wins over clear
      end
      KIL_MODE_EDGE_LEVEL:
      begin
        // ack kept until every enabled pin is high
        if (ack_pulse && request_q)
          acked_d = 1'b1;
        if (fall_event)
        begin
          request_d = 1'b1;
          acked_d = 1'b0;
        end
        else if (request_q && all_high && (acked_q || ack_pulse))
        begin
          request_d = 1'b0;
          acked_d = 1'b0;
        end
        if (any_low)
          request_d = 1'b1;
      end
      default:
      begin
        request_d = 1'b0;
        acked_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      request_q <= 1'b0;
      acked_q <= 1'b0;
    end
    else
    begin
      request_q <= request_d;
      acked_q <= acked_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb
  begin
    kbd_irq = request_q && !mask_q;
    kbd_vector_addr = KIL_VECTOR_HI;
  end

  // ****************************************************************
  // port pin control
  // ****************************************************************
  always_comb
  begin
    pin_pullup = enable_q;
    // keyboard enable overrides the direction bit
    pin_oe = dir_q & ~enable_q;
    pin_out = data_q;
  end

endmodule : kil_keypad_latch

//--- tb/kil_keys_model.sv
// far-side keys: switches to ground beside pullup or port drive
`timescale 1ns/1ps
module kil_keys_model
  import kil_pkg::*;
(
  input wire logic mclk, // bus clock
  input wire logic [KIL_NPINS-1:0] key_down, // pressed keys
  input wire logic [KIL_NPINS-1:0] pin_out, // port drive value
  input wire logic [KIL_NPINS-1:0] pin_oe, // port drive enable
  input wire logic [KIL_NPINS-1:0] pin_pullup, // pullup enable
  output logic [KIL_NPINS-1:0] pin_level // resolved pin level
);
  logic [KIL_NPINS-1:0] float_q = '0;
  always_ff @(posedge mclk)
    float_q <= ~float_q;
  // undriven pin with no pullup wanders every cycle
  always_comb
    for (int i = 0; i < KIL_NPINS; i++)
      pin_level[i] = key_down[i] ? 1'b0 : pin_oe[i] ? pin_out[i] :
                     pin_pullup[i] ? 1'b1 : float_q[i];
endmodule : kil_keys_model

//--- tb/kil_keypad_latch_sva.sv
// assertion checker for the keypad interrupt latch
`timescale 1ns/1ps
module kil_keypad_latch_sva
  import kil_pkg::*;
#(
  parameter int NPINS = KIL_NPINS
)(
  input wire logic mclk, // bus clock
  input wire logic rst_n, // async reset
  input wire kil_apb_req_t apb_req, // apb request
  input wire kil_apb_rsp_t apb_rsp, // apb answer
  input wire logic vector_fetch, // vector fetch
  input wire logic kbd_irq, // cpu request
  input wire logic [15:0] kbd_vector_addr, // vector address
  input wire logic [NPINS-1:0] pin_in, // pin levels
  input wire logic [NPINS-1:0] pin_out, // drive value
  input wire logic [NPINS-1:0] pin_oe, // drive enable
  input wire logic [NPINS-1:0] pin_pullup // pullup enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic wr_any;
  logic all_hi;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_any = acc && apb_req.pwrite;
  assign all_hi = &(pin_in | ~pin_pullup);
  sequence rd_sc_s;
    acc && !apb_req.pwrite && apb_req.paddr == KIL_OFF_STATUS_CONTROL;
  endsequence
  sequence wr_mask_s;
    wr_any && apb_req.paddr == KIL_OFF_STATUS_CONTROL &&
      apb_req.pwdata[KIL_BIT_MASK];
  endsequence
  mask_blocks_a: assert property (wr_mask_s |=> !kbd_irq)
    else $error("masked request reached cpu");
  pending_irq_a: assert property (rd_sc_s
    ##0 !apb_rsp.prdata[KIL_BIT_MASK]
    |-> apb_rsp.prdata[KIL_BIT_PENDING] == kbd_irq)
    else $error("pending flag differs from request");
  oe_pullup_a: assert property (!(|(pin_oe & pin_pullup)))
    else $error("driven pin has pullup on");
  vector_fixed_a: assert property (kbd_vector_addr == KIL_VECTOR_HI)
    else $error("vector address wrong");
  zero_wait_a: assert property (acc |-> apb_rsp.pready)
    else $error("pready missing in access");
  ack_reads_a: assert property (rd_sc_s
    |-> !apb_rsp.prdata[KIL_BIT_ACK])
    else $error("ack bit read as one");
  unmapped_err_a: assert property (acc && apb_req.paddr > KIL_OFF_PIN_LEVEL
    |-> apb_rsp.pslverr)
    else $error("unmapped access without error");
  idle_rdata_a: assert property (!(acc && !apb_req.pwrite)
    |-> apb_rsp.prdata == KIL_DATA_ZERO)
    else $error("read data outside read");
  irq_fall_a: assert property ($fell(kbd_irq)
    |-> $past(vector_fetch) || $past(wr_any) ||
    $past(all_hi, 2) || $past(all_hi, 3) || $past(all_hi, 4))
    else $error("request dropped without cause");
  irq_rise_a: assert property ($rose(kbd_irq) |-> $past(wr_any) ||
    !$past(all_hi, 2) || !$past(all_hi, 3) || !$past(all_hi, 4))
    else $error("request raised without cause");
endmodule : kil_keypad_latch_sva
bind kil_keypad_latch kil_keypad_latch_sva #(.NPINS(NPINS)) i_sva (
  .mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .vector_fetch(vector_fetch), .kbd_irq(kbd_irq),
  .kbd_vector_addr(kbd_vector_addr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pullup(pin_pullup));

//--- tb/kil_keypad_latch_tb_top.sv
// testbench top for the keypad interrupt latch
`timescale 1ns/1ps
module kil_keypad_latch_tb_top;
  import kil_pkg::*;
  localparam logic [11:0] SC = KIL_OFF_STATUS_CONTROL;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic vector_fetch = 1'b0;
  logic [4:0] key_down = 5'h00;
  kil_apb_req_t req = '0;
  kil_apb_rsp_t rsp;
  logic kbd_irq;
  logic [15:0] vec;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [4:0] pin_pullup;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;
  kil_keypad_latch i_kil_keypad_latch (.mclk(mclk), .rst_n(rst_n),
    .apb_req(req), .apb_rsp(rsp), .vector_fetch(vector_fetch),
    .kbd_irq(kbd_irq), .kbd_vector_addr(vec), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
  kil_keys_model i_kil_keys_model (.mclk(mclk), .key_down(key_down),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .pin_level(pin_in));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk
  task key(input logic [4:0] k);
    @(posedge mclk);
    key_down <= k;
    repeat (6) @(posedge mclk);
  endtask : key
  task fetch;
    @(posedge mclk);
    vector_fetch <= 1'b1;
    @(posedge mclk);
    vector_fetch <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : fetch
  task t_init;
    rd_chk(SC, 32'h0000_0000);
    rd_chk(KIL_OFF_ENABLE, 32'h0000_0000);
    apb(1'b1, KIL_OFF_PORT_DIR, 32'h0000_001F);
    apb(1'b1, KIL_OFF_PORT_DATA, 32'h0000_001F);
    apb(1'b1, SC, 32'h0000_0002);
    apb(1'b1, KIL_OFF_ENABLE, 32'h0000_001F);
    @(posedge mclk);
    check(32'(pin_pullup), 32'h0000_001F);
    check(32'(pin_oe), 32'h0000_0000);
    check(32'(pin_out), 32'h0000_001F);
    rd_chk(KIL_OFF_PIN_LEVEL, 32'h0000_0000);
    apb(1'b1, SC, 32'h0000_0006);
    rd_chk(SC, 32'h0000_0002);
    apb(1'b1, SC, 32'h0000_0000);
    apb(1'b1, KIL_OFF_PORT_DIR, 32'h0000_0000);
    rd_chk(KIL_OFF_PIN_LEVEL, 32'h0000_001F);
    apb(1'b0, 12'h014, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    $display("init test done");
  endtask : t_init
  task t_edge;
    key(5'h01);
    check(32'(kbd_irq), 32'h0000_0001);
    check(32'(vec), 32'h0000_FFE0);
    apb(1'b1, SC, 32'h0000_0004);
    rd_chk(SC, 32'h0000_0000);
    key(5'h03);
    rd_chk(SC, 32'h0000_0000);
    key(5'h00);
    key(5'h04);
    rd_chk(SC, 32'h0000_0008);
    apb(1'b1, SC, 32'h0000_0002);
    rd_chk(SC, 32'h0000_000A);
    check(32'(kbd_irq), 32'h0000_0000);
    fetch();
    rd_chk(SC, 32'h0000_0002);
    key(5'h00);
    apb(1'b1, SC, 32'h0000_0000);
    $display("edge test done");
  endtask : t_edge
  task t_level;
    apb(1'b1, SC, 32'h0000_0001);
    key(5'h08);
    rd_chk(SC, 32'h0000_0009);
    fetch();
    rd_chk(SC, 32'h0000_0009);
    key(5'h00);
    rd_chk(SC, 32'h0000_0001);
    key(5'h08);
    key(5'h00);
    check(32'(kbd_irq), 32'h0000_0001);
    apb(1'b1, SC, 32'h0000_0005);
    rd_chk(SC, 32'h0000_0001);
    $display("level test done");
  endtask : t_level
  task t_reset;
    key(5'h10);
    rd_chk(SC, 32'h0000_0009);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(SC, 32'h0000_0000);
    check(32'(kbd_irq), 32'h0000_0000);
    key(5'h00);
    $display("reset test done");
  endtask : t_reset
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_init();
    t_edge();
    t_level();
    t_reset();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule : kil_keypad_latch_tb_top
